// ===== rtl/ctx_test_pkg.sv
package ctx_test_pkg;

    // clock and pacing
    localparam int unsigned CLK_PERIOD_NS = 10;
    localparam int unsigned LOCK_NS       = 110000;  // synthesizer settle
    localparam int unsigned BYTE_NS_STD   = 32000;   // one byte at 250 kb/s
    localparam int unsigned BYTE_NS_FAST  = 4000;    // one byte at 2 Mb/s
    localparam int unsigned BYTE_CYC_STD  =
        (BYTE_NS_STD + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned BYTE_CYC_FAST =
        (BYTE_NS_FAST + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned LOCK_CYC_DEF  =
        (LOCK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // frame buffer geometry
    localparam int unsigned FB_DEPTH  = 128;
    localparam int unsigned FB_AW     = 7;
    localparam logic [6:0]  LEN_ADDR  = 7'h00;   // length byte position
    localparam logic [6:0]  DATA_ADDR = 7'h01;   // first payload byte

    // key values seen on register writes
    localparam logic [7:0] KEY_UNLOCK  = 8'h0F;
    localparam logic [7:0] KEY_ID_ONE  = 8'h54;
    localparam logic [7:0] KEY_ID_TWO  = 8'h46;
    localparam logic [7:0] KEY_LEAVE   = 8'h00;

    // command codes and state readback codes
    localparam logic [7:0] CMD_TX_START  = 8'h02;
    localparam logic [7:0] CMD_OFF       = 8'h03;
    localparam logic [7:0] CMD_PLL_ON    = 8'h09;
    localparam logic [7:0] STAT_BUSY_TX  = 8'h02;
    localparam logic [7:0] STAT_OFF      = 8'h08;
    localparam logic [7:0] STAT_PLL_ON   = 8'h09;

    // configuration values
    localparam logic [7:0] LOCK_IRQ_BIT  = 8'h01;
    localparam logic [7:0] CW_RATE_VAL   = 8'h03;
    localparam logic [7:0] CW_RX_VAL     = 8'hA7;
    localparam logic [7:0] PAT_LOWER     = 8'h00;
    localparam logic [7:0] PAT_UPPER     = 8'hFF;

    // which transceiver register a write targets
    typedef enum logic [3:0] {
        SEL_NONE,
        SEL_TEST_UNLOCK,
        SEL_PART_IDENTITY,
        SEL_COMMAND,
        SEL_CTRL_TWO,
        SEL_RX_CTRL,
        SEL_IRQ_MASK,
        SEL_CHANNEL,
        SEL_OUT_POWER
    } reg_sel_t;

    typedef enum logic [1:0] {
        UNL_IDLE, UNL_KEY1, UNL_KEY2, UNL_ON
    } unlock_st_t;

    typedef enum logic [1:0] {
        TRANSCEIVER_OFF_STATE_ST, TRX_PLL_ST, TRX_LOCKED_ST, TRX_BUSY_ST
    } trx_st_t;

    typedef struct packed {
        logic       valid;
        reg_sel_t   sel;
        logic [7:0] data;
    } reg_write_t;

    typedef struct packed {
        logic       valid;
        logic [6:0] addr;
        logic [7:0] data;
    } fb_write_t;

    typedef struct packed {
        logic       valid;      // one-cycle pulse per sent byte
        logic [7:0] data;       // psdu byte being modulated
        logic       cw_on;      // tone instead of modulation
        logic       cw_upper;   // 1: centre + 0.5 MHz, 0: centre - 0.5 MHz
    } tx_out_t;

endpackage

// ===== rtl/continuous_tx_test_mode.sv
`timescale 1ns/1ps
module continuous_tx_test_mode #(
    parameter int unsigned LOCK_CYCLES = ctx_test_pkg::LOCK_CYC_DEF
) (
    // clock and reset
    input  wire logic                    core_clk,
    input  wire logic                    nrst,
    // register writes from the processor side
    input  wire ctx_test_pkg::reg_write_t reg_wr,
    // frame buffer writes
    input  wire ctx_test_pkg::fb_write_t  fb_wr,
    // transmit stream towards the modulator
    output ctx_test_pkg::tx_out_t         tx_out,
    // status
    output logic                          test_active,
    output logic [7:0]                    transceiver_state_readback,
    output logic                          lock_irq
);
    import ctx_test_pkg::*;

    // frame buffer storage; byte 0 holds the psdu length
    logic [7:0] fb_mem [FB_DEPTH];

    unlock_st_t  unl_reg;           // enable sequence progress
    trx_st_t     trx_reg;           // transceiver state
    logic [31:0] lock_cnt_reg;      // synthesizer settle counter
    logic [31:0] byte_cnt_reg;      // byte pacing divider
    logic        byte_tick;         // one-cycle enable per byte slot
    logic [6:0]  rd_ptr_reg;        // next payload byte to send
    logic        mask_lock_reg;     // lock interrupt allowed
    logic        rate_fast_reg;     // high data rate selected
    logic        rx_cw_reg;         // receive control set for cw
    logic        mode_cw_reg;       // cw chosen, latched at tx start
    logic        tone_up_reg;       // current tone side
    logic [6:0]  psdu_len;          // length taken from byte 0
    logic [7:0]  cur_byte;          // payload byte under the pointer
    logic        streaming;         // test transmission running

    // true when this cycle carries a write of value v to register s
    function automatic logic wr_hit(input reg_write_t w,
                                    input reg_sel_t   s,
                                    input logic [7:0] v);
        return w.valid && (w.sel == s) && (w.data == v);
    endfunction

    // true when register s is written with anything
    function automatic logic wr_any(input reg_write_t w,
                                    input reg_sel_t   s);
        return w.valid && (w.sel == s);
    endfunction

    assign psdu_len  = fb_mem[LEN_ADDR][6:0];
    assign cur_byte  = fb_mem[rd_ptr_reg];
    assign streaming = (unl_reg == UNL_ON) && (trx_reg == TRX_BUSY_ST);

    // frame buffer write port; no reset so it maps onto a ram
    always_ff @(posedge core_clk) begin
        if (fb_wr.valid) begin
            fb_mem[fb_wr.addr] <= fb_wr.data;
        end
    end

    // three-key enable sequence; a stray key before the last one drops back to idle
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            unl_reg <= UNL_IDLE;
        end else if (wr_hit(reg_wr, SEL_TEST_UNLOCK, KEY_UNLOCK)) begin
            unl_reg <= UNL_KEY1;
        end else if (wr_any(reg_wr, SEL_TEST_UNLOCK)) begin
            unl_reg <= UNL_IDLE;
        end else if (wr_any(reg_wr, SEL_PART_IDENTITY)) begin
            case (unl_reg)
                UNL_KEY1: begin
                    // second key must follow the unlock write
                    unl_reg <= (reg_wr.data == KEY_ID_ONE) ?
                               UNL_KEY2 : UNL_IDLE;
                end
                UNL_KEY2: begin
                    unl_reg <= (reg_wr.data == KEY_ID_TWO) ?
                               UNL_ON : UNL_IDLE;
                end
                UNL_ON: begin
                    // among identity writes only the leave key ends the mode, others are ignored
                    if (reg_wr.data == KEY_LEAVE) begin
                        unl_reg <= UNL_IDLE;
                    end
                end
                default: begin
                    unl_reg <= UNL_IDLE;
                end
            endcase
        end
    end

    // configuration bits captured from plain register writes
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            mask_lock_reg <= 1'b0;
            rate_fast_reg <= 1'b0;
            rx_cw_reg     <= 1'b0;
        end else begin
            if (wr_any(reg_wr, SEL_IRQ_MASK)) begin
                mask_lock_reg <= |(reg_wr.data & LOCK_IRQ_BIT);
            end
            if (wr_any(reg_wr, SEL_CTRL_TWO)) begin
                rate_fast_reg <= (reg_wr.data == CW_RATE_VAL);
            end
            if (wr_any(reg_wr, SEL_RX_CTRL)) begin
                rx_cw_reg <= (reg_wr.data == CW_RX_VAL);
            end
        end
    end

    // transceiver state: off, settling, locked, busy transmitting
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            trx_reg      <= TRANSCEIVER_OFF_STATE_ST;
            lock_cnt_reg <= '0;
        end else if (wr_hit(reg_wr, SEL_COMMAND, CMD_OFF)) begin
            trx_reg      <= TRANSCEIVER_OFF_STATE_ST;
            lock_cnt_reg <= '0;
        end else begin
            case (trx_reg)
                TRANSCEIVER_OFF_STATE_ST: begin
                    if (wr_hit(reg_wr, SEL_COMMAND, CMD_PLL_ON)) begin
                        trx_reg      <= TRX_PLL_ST;
                        lock_cnt_reg <= '0;
                    end
                end
                TRX_PLL_ST: begin
                    // settle time must pass before the lock event
                    if (lock_cnt_reg >= LOCK_CYCLES - 1) begin
                        trx_reg <= TRX_LOCKED_ST;
                    end else begin
                        lock_cnt_reg <= lock_cnt_reg + 32'd1;
                    end
                end
                TRX_LOCKED_ST: begin
                    // start is only honoured once locked
                    if (wr_hit(reg_wr, SEL_COMMAND, CMD_TX_START)) begin
                        trx_reg <= TRX_BUSY_ST;
                    end
                end
                TRX_BUSY_ST: begin
                    // busy state never ends by itself; only off or reset
                    trx_reg <= TRX_BUSY_ST;
                end
                default: begin
                    trx_reg <= TRANSCEIVER_OFF_STATE_ST;
                end
            endcase
        end
    end

    // lock interrupt pulse, gated by the mask bit
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            lock_irq <= 1'b0;
        end else begin
            lock_irq <= (trx_reg == TRX_PLL_ST) &&
                        (lock_cnt_reg >= LOCK_CYCLES - 1) &&
                        mask_lock_reg;
        end
    end

    // state readback code
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            transceiver_state_readback <= STAT_OFF;
        end else begin
            case (trx_reg)
                TRANSCEIVER_OFF_STATE_ST:    transceiver_state_readback <= STAT_OFF;
                TRX_BUSY_ST:   transceiver_state_readback <= STAT_BUSY_TX;
                default:       transceiver_state_readback <= STAT_PLL_ON;
            endcase
        end
    end

    // mode enable flag out
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            test_active <= 1'b0;
        end else begin
            test_active <= (unl_reg == UNL_ON);
        end
    end

    // cw choice frozen at start so later writes cannot disturb a run
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            mode_cw_reg <= 1'b0;
        end else if (trx_reg != TRX_BUSY_ST) begin
            mode_cw_reg <= rate_fast_reg && rx_cw_reg;
        end
    end

    // byte slot divider; fast slots only when cw mode is latched, standard slots otherwise
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            byte_cnt_reg <= '0;
            byte_tick    <= 1'b0;
        end else if (!streaming) begin
            byte_cnt_reg <= '0;
            byte_tick    <= 1'b0;
        end else if (byte_cnt_reg >= (mode_cw_reg ? BYTE_CYC_FAST - 1 :
                                      BYTE_CYC_STD - 1)) begin
            byte_cnt_reg <= '0;
            byte_tick    <= 1'b1;
        end else begin
            byte_cnt_reg <= byte_cnt_reg + 32'd1;
            byte_tick    <= 1'b0;
        end
    end

    // payload pointer; starts at the first psdu byte and wraps forever
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            rd_ptr_reg <= DATA_ADDR;
        end else if (!streaming) begin
            rd_ptr_reg <= DATA_ADDR;
        end else if (byte_tick) begin
            // a zero length frame has nothing to repeat
            if (rd_ptr_reg >= psdu_len) begin
                rd_ptr_reg <= DATA_ADDR;
            end else begin
                rd_ptr_reg <= rd_ptr_reg + 7'd1;
            end
        end
    end

    // tone side: 0x00 lower, 0xFF upper; other bytes keep the last
    // side so the centre frequency is never produced
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            tone_up_reg <= 1'b0;
        end else if (byte_tick && mode_cw_reg) begin
            if (cur_byte == PAT_UPPER) begin
                tone_up_reg <= 1'b1;
            end else if (cur_byte == PAT_LOWER) begin
                tone_up_reg <= 1'b0;
            end
        end
    end

    // stream output: payload bytes only, no header, tone flags alongside
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            tx_out <= '0;
        end else begin
            tx_out.valid    <= byte_tick && streaming &&
                               (psdu_len != 7'd0);
            if (byte_tick) begin
                tx_out.data <= cur_byte;
            end
            tx_out.cw_on    <= streaming && mode_cw_reg;
            if (byte_tick && mode_cw_reg) begin
                tx_out.cw_upper <= (cur_byte == PAT_UPPER) ? 1'b1 :
                                   (cur_byte == PAT_LOWER) ? 1'b0 :
                                   tone_up_reg;
            end
        end
    end

endmodule

// ===== tb/ctx_test_chk.sv
`timescale 1ns/1ps
module ctx_test_chk
    import ctx_test_pkg::*;
#(
    parameter int unsigned LOCK_CYCLES = 4
) (
    // clock and reset
    input wire logic                    core_clk,
    input wire logic                    nrst,
    // writes seen by the block
    input wire ctx_test_pkg::reg_write_t reg_wr,
    input wire ctx_test_pkg::fb_write_t  fb_wr,
    // watched outputs
    input wire ctx_test_pkg::tx_out_t    tx_out,
    input wire logic                    test_active,
    input wire logic [7:0]              transceiver_state_readback,
    input wire logic                    lock_irq
);
    import ctx_test_pkg::*;
    logic w_part;    // identity register written
    logic w_unl;     // first key
    logic w_k2;      // last key
    logic w_pll;     // synthesizer on command
    logic w_off;     // off command
    logic mask_reg;  // last lock mask bit, ties an irq to its enable
    assign w_part = reg_wr.valid && reg_wr.sel == SEL_PART_IDENTITY;
    assign w_unl  = reg_wr.valid && reg_wr.sel == SEL_TEST_UNLOCK
                    && reg_wr.data == KEY_UNLOCK;
    assign w_k2   = w_part && reg_wr.data == KEY_ID_TWO;
    assign w_pll  = reg_wr.valid && reg_wr.sel == SEL_COMMAND
                    && reg_wr.data == CMD_PLL_ON;
    assign w_off  = reg_wr.valid && reg_wr.sel == SEL_COMMAND
                    && reg_wr.data == CMD_OFF;
    // mask shadow follows every mask write
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            mask_reg <= 1'b0;
        end else if (reg_wr.valid && reg_wr.sel == SEL_IRQ_MASK) begin
            mask_reg <= reg_wr.data[0];
        end
    end
    default clocking @(posedge core_clk); endclocking
    default disable iff (!nrst);
    // three keys back to back
    sequence s_unlock;
        w_unl ##1 (w_part && reg_wr.data == KEY_ID_ONE) ##1 w_k2;
    endsequence
    // synthesizer on while settled off, not overridden next cycle
    sequence s_pll;
        w_pll && transceiver_state_readback == STAT_OFF && $past(transceiver_state_readback) == STAT_OFF
        ##1 !w_off;
    endsequence
    a_key_unlock: assert property (s_unlock |-> ##2 test_active)
        else $error("unlock keys did not enable test mode");
    a_no_stray_on: assert property ($rose(test_active) |-> $past(w_k2, 2))
        else $error("test mode rose without last key");
    a_leave_mode: assert property (
        w_part && reg_wr.data == KEY_LEAVE && test_active |-> ##2 !test_active)
        else $error("test mode kept after leave key");
    a_tone_side: assert property (tx_out.valid && tx_out.cw_on
        && (tx_out.data == PAT_UPPER || tx_out.data == PAT_LOWER)
        |-> tx_out.cw_upper == (tx_out.data == PAT_UPPER))
        else $error("tone side does not match pattern byte");
    a_stream_gate: assert property (
        tx_out.valid |-> test_active || $past(test_active))
        else $error("byte sent outside test mode");
    a_pulse_gap: assert property (tx_out.valid |=> !tx_out.valid [*8])
        else $error("byte pulses too close");
    a_lock_cause: assert property (
        lock_irq |-> mask_reg && transceiver_state_readback == STAT_PLL_ON)
        else $error("lock irq without mask or settling state");
    a_pll_answer: assert property (s_pll |-> ##1 transceiver_state_readback == STAT_PLL_ON)
        else $error("synthesizer state not shown");
    a_off_answer: assert property (
        w_off ##1 !w_pll |-> ##1 transceiver_state_readback == STAT_OFF)
        else $error("off state not shown");
endmodule
bind continuous_tx_test_mode ctx_test_chk #(.LOCK_CYCLES(LOCK_CYCLES))
    ctx_test_chk_i (.core_clk(core_clk), .nrst(nrst), .reg_wr(reg_wr),
    .fb_wr(fb_wr), .tx_out(tx_out), .test_active(test_active),
    .transceiver_state_readback(transceiver_state_readback), .lock_irq(lock_irq));

// ===== tb/continuous_tx_test_mode_tb.sv
`timescale 1ns/1ps
module continuous_tx_test_mode_tb;
    import ctx_test_pkg::*;
    localparam int unsigned LOCK = 4;  // short settle keeps the run brief
    logic       core_clk;
    logic       nrst;
    reg_write_t reg_wr;
    fb_write_t  fb_wr;
    tx_out_t    tx_out;
    logic       test_active;
    logic [7:0] transceiver_state_readback;
    logic       lock_irq;
    int         error_cnt;
    int         tests_run;
    logic [7:0] pat [$];  // payload of the current frame
    continuous_tx_test_mode #(.LOCK_CYCLES(LOCK)) continuous_tx_test_mode_i (
        .core_clk(core_clk), .nrst(nrst), .reg_wr(reg_wr), .fb_wr(fb_wr),
        .tx_out(tx_out), .test_active(test_active),
        .transceiver_state_readback(transceiver_state_readback), .lock_irq(lock_irq));
    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end
    task automatic report_and_stop;
        $display("checks %0d errors %0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        tests_run++;
        if (got !== exp) begin
            error_cnt++;
            $display("[FAIL] t=%0t got=%0h exp=%0h", $time, got, exp);
        end
    endtask
    // strobe stays up between calls, so writes may run back to back
    task automatic wr(input reg_sel_t s, input logic [7:0] d);
        reg_wr = '{1'b1, s, d};
        @(negedge core_clk);
    endtask
    task automatic rel;
        reg_wr.valid = 1'b0;
        @(negedge core_clk);
    endtask
    task automatic do_reset;
        nrst = 1'b0;
        repeat (12) @(negedge core_clk);
        nrst = 1'b1;
        @(negedge core_clk);
    endtask
    // length byte first, then the payload
    task automatic load;
        fb_wr = '{1'b1, LEN_ADDR, 8'(pat.size())};
        @(negedge core_clk);
        foreach (pat[i]) begin
            fb_wr = '{1'b1, 7'(i + 1), pat[i]};
            @(negedge core_clk);
        end
        fb_wr.valid = 1'b0;
    endtask
    task automatic unlock(input logic cw);
        wr(SEL_IRQ_MASK, LOCK_IRQ_BIT);
        wr(SEL_COMMAND, CMD_OFF);
        rel;
        rel;
        chk(transceiver_state_readback, STAT_OFF);
        wr(SEL_TEST_UNLOCK, KEY_UNLOCK);
        if (cw) begin
            wr(SEL_CTRL_TWO, CW_RATE_VAL);
            wr(SEL_RX_CTRL, CW_RX_VAL);
        end
        rel;
        load;
        wr(SEL_PART_IDENTITY, KEY_ID_ONE);
        wr(SEL_PART_IDENTITY, KEY_ID_TWO);
        rel;
        rel;
        chk(test_active, 1'b1);
    endtask
    // an early start must be ignored until the synthesizer locks
    task automatic start_tx;
        int n;
        wr(SEL_COMMAND, CMD_PLL_ON);
        wr(SEL_COMMAND, CMD_TX_START);
        rel;
        rel;
        chk(transceiver_state_readback, STAT_PLL_ON);
        n = 0;
        while (lock_irq !== 1'b1 && n < LOCK + 10) begin
            @(negedge core_clk);
            n++;
        end
        chk(lock_irq, 1'b1);
        if (lock_irq !== 1'b1) report_and_stop;
        wr(SEL_COMMAND, CMD_TX_START);
        rel;
        rel;
        chk(transceiver_state_readback, STAT_BUSY_TX);
    endtask
    task automatic next_byte(output int n);
        n = 0;
        do begin
            @(negedge core_clk);
            n++;
        end while (tx_out.valid !== 1'b1 && n < 4000);
        if (tx_out.valid !== 1'b1) begin
            error_cnt++;
            report_and_stop;
        end
    endtask
    // checks cnt bytes; two laps of a short frame show the wrap past the last byte
    task automatic expect_stream(input logic cw, input int gap,
                                 input int cnt);
        int n;
        logic [7:0] b;
        for (int i = 0; i < cnt; i++) begin
            next_byte(n);
            b = pat[i % pat.size()];
            if (i > 0) chk(16'(n), 16'(gap));
            chk(tx_out.data, b);
            chk(tx_out.cw_on, cw);
            if (cw) chk(tx_out.cw_upper, b == PAT_UPPER);
        end
    endtask
    task automatic leave;
        int hits;
        hits = 0;
        wr(SEL_PART_IDENTITY, KEY_LEAVE);
        rel;
        rel;
        chk(test_active, 1'b0);
        // watch longer than the slow byte slot, or a stuck stream hides
        repeat (BYTE_CYC_STD + 8) begin
            @(negedge core_clk);
            if (tx_out.valid === 1'b1) hits++;
        end
        chk(16'(hits), 16'h0000);
        do_reset;
    endtask
    task automatic sc_reset;
        chk(test_active, 1'b0);
        chk(transceiver_state_readback, STAT_OFF);
        chk(16'(tx_out), 16'h0000);
        chk(lock_irq, 1'b0);
    endtask
    // wrong key, order broken by a bad unlock write between the second and last keys, then a clean unlock
    task automatic sc_bad_keys;
        wr(SEL_TEST_UNLOCK, KEY_UNLOCK);
        wr(SEL_PART_IDENTITY, KEY_ID_TWO);
        wr(SEL_PART_IDENTITY, KEY_ID_ONE);
        wr(SEL_PART_IDENTITY, KEY_ID_TWO);
        rel;
        rel;
        chk(test_active, 1'b0);
        wr(SEL_TEST_UNLOCK, KEY_UNLOCK);
        wr(SEL_PART_IDENTITY, KEY_ID_ONE);
        wr(SEL_TEST_UNLOCK, 8'h0E);
        wr(SEL_PART_IDENTITY, KEY_ID_TWO);
        rel;
        rel;
        chk(test_active, 1'b0);
        wr(SEL_TEST_UNLOCK, KEY_UNLOCK);
        wr(SEL_PART_IDENTITY, KEY_ID_ONE);
        wr(SEL_PART_IDENTITY, KEY_ID_TWO);
        rel;
        rel;
        chk(test_active, 1'b1);
        leave;
    endtask
    task automatic sc_cw;
        pat = '{PAT_UPPER, PAT_LOWER};
        unlock(1'b1);
        start_tx;
        expect_stream(1'b1, BYTE_CYC_FAST, 2 * pat.size());
        leave;
    endtask
    task automatic sc_prbs;
        pat = '{8'h11, 8'h22, 8'h33};
        unlock(1'b0);
        start_tx;
        expect_stream(1'b0, BYTE_CYC_STD, 2 * pat.size());
        leave;
    endtask
    // longest frame from a shift register; only the head is timed,
    // since a full lap at the slow rate would run far too long
    task automatic sc_long;
        logic [7:0] s;
        s = 8'hA5;
        pat.delete();
        repeat (FB_DEPTH - 1) begin
            s = {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
            pat.push_back(s);
        end
        unlock(1'b0);
        start_tx;
        expect_stream(1'b0, BYTE_CYC_STD, 3);
        leave;
    endtask
    initial begin
        nrst = 1'b0;
        reg_wr = '0;
        fb_wr = '0;
        error_cnt = 0;
        tests_run = 0;
        do_reset;
        sc_reset;
        sc_bad_keys;
        sc_cw;
        sc_prbs;
        sc_long;
        report_and_stop;
    end
endmodule
